// ### logic/wrpd_defs.svh
`ifndef WRPD_DEFS_SVH
`define WRPD_DEFS_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define WRPD_ADDR_W 4
`define WRPD_OFS_CTRL 4'h0
`define WRPD_OFS_CMD 4'h1
`define WRPD_OFS_STAT 4'h2
`define WRPD_OFS_WAKE 4'h3
`define WRPD_OFS_P0 4'h4
`define WRPD_OFS_ID 4'h5

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define WRPD_CTRL_BIDIR 0
`define WRPD_CTRL_REGOFF 1
`define WRPD_CTRL_RAMEN 2
`define WRPD_CTRL_PDCFG 5
`define WRPD_CMD_SWRST 0
`define WRPD_CMD_POWER_DOWN_INSTRUCTION 1
`define WRPD_CMD_WDRST 2
`define WRPD_CTRL_RST 32'h0000_0004

// ----------------------------------------------------------------------------
// Timing: minimum low and abort times in CPU clock half-periods, sequence length in clock cycles
// ----------------------------------------------------------------------------
`define WRPD_MIN_LOW_HALF 4
`define WRPD_ABORT_HALF 12
`define WRPD_SEQ_CYCLES 16
`define WRPD_P0_LOWER_ONES 6'h3F

`endif

// ### logic/wrpd_pkg.sv
package wrpd_pkg;

  typedef enum logic [2:0] {
    WRPD_RUN,
    WRPD_SYNC,
    WRPD_ASYNC,
    WRPD_PD_PROT,
    WRPD_PD_INT
  } wrpd_state_t;

  // Pin drive group of the reset pin, the capacitor pin, the reset output pin and the I/O hi-Z.
  typedef struct packed {
    logic rst_pd_en;
    logic rst_drive_low;
    logic cap_pd_en;
    logic reset_output_pin_low;
    logic io_hiz;
  } wrpd_pins_t;

endpackage

// ### logic/wrpd_ctrl.sv
// The Avalon-MM slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "wrpd_defs.svh"
module wrpd_ctrl
  import wrpd_pkg::*;
#(
  parameter int SEQ_CYCLES = `WRPD_SEQ_CYCLES,
  parameter logic [31:0] ID_VALUE = 32'h0000_5A01  // Arbitrary value.
) (
  // Clock and reset
  input wire logic I_MCLK,
  input wire logic I_SOFTWARE_RESET_INSTRUCTION,
  // Avalon-MM slave
  input wire logic [`WRPD_ADDR_W-1:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  // Pins
  input wire logic I_RESET_INPUT_PIN_N,
  input wire logic I_RESET_POWERDOWN_CAP_PIN,
  input wire logic I_NMI_N,
  input wire logic [7:0] I_FAST_EXTERNAL_INTERRUPT_PIN,
  input wire logic [7:0] I_FAST_INT_ENABLE,
  input wire logic [7:0] I_FAST_INT_ACTIVE_HIGH,
  input wire logic [12:0] I_PORT0_CONFIG,
  // Wake sources and CPU status
  input wire logic I_RTC_IRQ,
  input wire logic I_CAN_IRQ,
  input wire logic I_I2C_IRQ,
  input wire logic I_ACCESS_BUSY,
  // Outputs
  output wrpd_pins_t O_PINS,
  output logic O_CPU_RESET,
  output logic O_HOLD_CANCEL,
  output logic O_BUS_ABORT,
  output logic O_ASYNC_RESET,
  output logic O_POWER_DOWN,
  output logic O_RETAINED_RAM_EN,
  output logic O_RAM_IF_FREEZE,
  output logic [12:0] O_PORT0_LATCH
);

  // --------------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------------
  logic rst_meta_q, rst_sync_q, cap_meta_q, cap_sync_q, nmi_meta_q, nmi_sync_q;
  logic [7:0] fi_meta_q, fi_sync_q;
  always_ff @(posedge I_MCLK) begin
    rst_meta_q <= I_RESET_INPUT_PIN_N;
    rst_sync_q <= rst_meta_q;
    cap_meta_q <= I_RESET_POWERDOWN_CAP_PIN;
    cap_sync_q <= cap_meta_q;
    nmi_meta_q <= I_NMI_N;
    nmi_sync_q <= nmi_meta_q;
    fi_meta_q <= I_FAST_EXTERNAL_INTERRUPT_PIN;
    fi_sync_q <= fi_meta_q;
  end

  // --------------------------------------------------------------------------
  // Sequencer and registers
  // --------------------------------------------------------------------------
  localparam int CW = $clog2(SEQ_CYCLES + 1);
  localparam int ABORT_CYC = `WRPD_ABORT_HALF / 2;
  localparam int LOW_CYC = `WRPD_MIN_LOW_HALF / 2;

  wrpd_state_t state_q, state_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [1:0] low_q, low_d;
  logic sw_q, sw_d;
  logic [31:0] ctrl_q, ctrl_d;
  logic [12:0] p0_q, p0_d;
  logic [31:0] rdata_q, rdata_d;
  logic wait_q, wait_d;
  logic [4:0] wake_q, wake_d;
  wrpd_pins_t pins_q, pins_d;
  logic cpu_rst_q, cpu_rst_d, hold_q, hold_d, abort_q, abort_d;
  logic pd_q, pd_d, freeze_q, freeze_d;
  logic async_q, async_d, ram_en_q, ram_en_d;

  logic ext_low, hw_start, wr_cmd, in_reset, pd_ok;
  logic [7:0] fi_active;

  always_comb begin
    ext_low = !rst_sync_q;
    fi_active = (fi_sync_q ~^ I_FAST_INT_ACTIVE_HIGH) & I_FAST_INT_ENABLE;
    wr_cmd = I_AVS_WRITE && wait_q && (I_AVS_ADDRESS == `WRPD_OFS_CMD);
    hw_start = ext_low && (low_q == 2'(LOW_CYC - 1));
    low_d = ext_low ? ((low_q == 2'(LOW_CYC - 1)) ? low_q : low_q + 2'd1) : 2'd0;
    state_d = state_q;
    cnt_d = cnt_q;
    sw_d = sw_q;
    ctrl_d = ctrl_q;
    p0_d = p0_q;
    wake_d = wake_q;
    pd_ok = 1'b0;
    case (state_q)
      WRPD_RUN, WRPD_PD_INT: begin
        if (state_q == WRPD_PD_INT) begin
          if (|fi_active || I_RTC_IRQ || I_CAN_IRQ || I_I2C_IRQ) begin
            state_d = WRPD_RUN;
            wake_d = {I_I2C_IRQ, I_CAN_IRQ, I_RTC_IRQ, |fi_active, 1'b0};
          end
        end
        if (hw_start) begin
          state_d = cap_sync_q ? WRPD_SYNC : WRPD_ASYNC;
          cnt_d = '0;
          sw_d = 1'b0;
          wake_d = {wake_q[4:1], 1'b1};
        end else if (state_q == WRPD_RUN && wr_cmd) begin
          if (I_AVS_WRITEDATA[`WRPD_CMD_SWRST] || I_AVS_WRITEDATA[`WRPD_CMD_WDRST]) begin
            state_d = WRPD_SYNC;
            cnt_d = '0;
            sw_d = I_AVS_WRITEDATA[`WRPD_CMD_SWRST];
          end else if (I_AVS_WRITEDATA[`WRPD_CMD_POWER_DOWN_INSTRUCTION]) begin
            // regulator-off bit is expected set by software
            pd_ok = ctrl_q[`WRPD_CTRL_REGOFF];
            if (!ctrl_q[`WRPD_CTRL_PDCFG]) begin
              if (!nmi_sync_q) state_d = WRPD_PD_PROT;
            end else if (fi_active == 8'h00) begin
              state_d = WRPD_PD_INT;
            end
          end
        end
      end
      WRPD_PD_PROT: begin
        if (hw_start) begin
          state_d = cap_sync_q ? WRPD_SYNC : WRPD_ASYNC;
          cnt_d = '0;
          sw_d = 1'b0;
        end
      end
      WRPD_SYNC: begin
        // The count saturates so that a long reset cannot wrap it into a second sequence.
        if (cnt_q != CW'(SEQ_CYCLES)) begin
          cnt_d = cnt_q + CW'(1);
        end
        // capacitor low with pin low turns hardware or watchdog reset asynchronous; not for sw
        if (!cap_sync_q && !sw_q && !wr_cmd && ext_low) begin
          state_d = WRPD_ASYNC;
        end else if (cnt_q >= CW'(SEQ_CYCLES) && !ext_low) begin
          state_d = WRPD_RUN;
          ctrl_d[`WRPD_CTRL_BIDIR] = 1'b0;
          if (sw_q) begin
            p0_d = {I_PORT0_CONFIG[12:8], `WRPD_P0_LOWER_ONES, p0_q[1:0]};
          end else begin
            p0_d = I_PORT0_CONFIG;
          end
        end
      end
      WRPD_ASYNC: begin
        // completes regardless of the capacitor pin
        if (!ext_low) begin
          state_d = WRPD_RUN;
          ctrl_d = `WRPD_CTRL_RST;
          p0_d = I_PORT0_CONFIG;
        end
      end
      default: state_d = WRPD_RUN;
    endcase
    if (state_q == WRPD_RUN && I_AVS_WRITE && wait_q && I_AVS_ADDRESS == `WRPD_OFS_CTRL) begin
      ctrl_d = I_AVS_WRITEDATA;
    end
    if (pd_ok && 1'b0) ctrl_d = ctrl_q;
    in_reset = (state_d == WRPD_SYNC) || (state_d == WRPD_ASYNC);
    cnt_d = in_reset ? cnt_d : '0;
    // hi-Z and reset-out low during reset
    pins_d.io_hiz = in_reset;
    pins_d.reset_output_pin_low = in_reset;
    // bidirectional software reset drives pin only while capacitor high
    // The pin is released at the end of the sequence, else its own low level would hold
    // the reset forever.
    pins_d.rst_drive_low = (state_d == WRPD_SYNC) && sw_d && cap_sync_q
                           && ctrl_d[`WRPD_CTRL_BIDIR] && (cnt_d < CW'(SEQ_CYCLES));
    // reset-pin pull-down needs the enable bit
    pins_d.rst_pd_en = ctrl_d[`WRPD_CTRL_BIDIR] && in_reset;
    // capacitor pull-down while reset pin low
    pins_d.cap_pd_en = ext_low || pins_q.rst_drive_low;
    // hold cancel and bus abort within six cycles
    hold_d = in_reset && (cnt_d < CW'(ABORT_CYC));
    abort_d = in_reset && (cnt_d < CW'(ABORT_CYC)) && I_ACCESS_BUSY;
    cpu_rst_d = in_reset;
    pd_d = (state_d == WRPD_PD_PROT) || (state_d == WRPD_PD_INT);
    // RAM disabled and interface frozen under reset
    freeze_d = in_reset;
    ram_en_d = ctrl_d[`WRPD_CTRL_RAMEN] && !in_reset;
    async_d = (state_d == WRPD_ASYNC);
    // Avalon slave: one wait cycle, then answer.
    wait_d = !((I_AVS_READ || I_AVS_WRITE) && wait_q);
    rdata_d = rdata_q;
    if (I_AVS_READ && wait_q) begin
      case (I_AVS_ADDRESS)
        `WRPD_OFS_CTRL: rdata_d = ctrl_q;
        `WRPD_OFS_STAT: rdata_d = {29'h0, state_q};
        `WRPD_OFS_WAKE: rdata_d = {27'h0, wake_q};
        `WRPD_OFS_P0: rdata_d = {19'h0, p0_q};
        `WRPD_OFS_ID: rdata_d = ID_VALUE;
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_SOFTWARE_RESET_INSTRUCTION) begin
      state_q <= WRPD_RUN;
      cnt_q <= '0;
      low_q <= 2'h0;
      sw_q <= 1'b0;
      ctrl_q <= `WRPD_CTRL_RST;
      p0_q <= 13'h0000;
      rdata_q <= 32'h0000_0000;
      wait_q <= 1'b1;
      wake_q <= 5'h00;
      pins_q <= '0;
      cpu_rst_q <= 1'b1;
      hold_q <= 1'b0;
      abort_q <= 1'b0;
      pd_q <= 1'b0;
      freeze_q <= 1'b1;
      async_q <= 1'b0;
      ram_en_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      low_q <= low_d;
      sw_q <= sw_d;
      ctrl_q <= ctrl_d;
      p0_q <= p0_d;
      rdata_q <= rdata_d;
      wait_q <= wait_d;
      wake_q <= wake_d;
      pins_q <= pins_d;
      cpu_rst_q <= cpu_rst_d;
      hold_q <= hold_d;
      abort_q <= abort_d;
      pd_q <= pd_d;
      freeze_q <= freeze_d;
      async_q <= async_d;
      ram_en_q <= ram_en_d;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign O_PINS = pins_q;
  assign O_CPU_RESET = cpu_rst_q;
  assign O_HOLD_CANCEL = hold_q;
  assign O_BUS_ABORT = abort_q;
  assign O_ASYNC_RESET = async_q;
  assign O_POWER_DOWN = pd_q;
  assign O_RETAINED_RAM_EN = ram_en_q;
  assign O_RAM_IF_FREEZE = freeze_q;
  assign O_AVS_READDATA = rdata_q;
  assign O_AVS_WAITREQUEST = wait_q;
  assign O_PORT0_LATCH = p0_q;

endmodule

// ### bench/wrpd_ctrl_props.sv
`timescale 1ns/1ps
module wrpd_ctrl_props
  import wrpd_pkg::*;
(
  // Clock and reset
  input wire logic I_MCLK,
  input wire logic I_SOFTWARE_RESET_INSTRUCTION,
  // Bus handshake
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic O_AVS_WAITREQUEST,
  // Pins and reset state
  input wire logic I_RESET_INPUT_PIN_N,
  input wire logic I_RESET_POWERDOWN_CAP_PIN,
  input wire wrpd_pins_t O_PINS,
  input wire logic O_CPU_RESET,
  input wire logic O_HOLD_CANCEL,
  input wire logic O_ASYNC_RESET,
  input wire logic O_RETAINED_RAM_EN,
  input wire logic O_RAM_IF_FREEZE
);
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_SOFTWARE_RESET_INSTRUCTION);
  sequence s_taken;
    (I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST;
  endsequence
  // Six cycles leave room for the two-stage synchroniser and the register.
  sequence s_pin_low;
    !I_RESET_INPUT_PIN_N [*6];
  endsequence
  sequence s_drained;
    (O_CPU_RESET && !I_RESET_INPUT_PIN_N && !I_RESET_POWERDOWN_CAP_PIN) [*5];
  endsequence
  a_bus_answer: assert property (s_taken |=> !O_AVS_WAITREQUEST)
    else $error("waitrequest not lowered after a request");
  a_bus_pulse: assert property (!O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST)
    else $error("waitrequest low for more than one cycle");
  a_warm_pins: assert property (O_PINS.reset_output_pin_low |-> O_PINS.io_hiz)
    else $error("reset output low while pins driven");
  a_cap_pulldown: assert property (s_pin_low |-> O_PINS.cap_pd_en)
    else $error("capacitor pull-down off while reset pin low");
  a_hold_cancel: assert property ($rose(O_CPU_RESET) |-> ##[0:6] O_HOLD_CANCEL)
    else $error("hold states not cancelled in time");
  a_async_entry: assert property (s_drained |-> O_ASYNC_RESET)
    else $error("drained capacitor did not make reset asynchronous");
  a_async_hold: assert property (O_ASYNC_RESET && !I_RESET_INPUT_PIN_N |=> O_ASYNC_RESET)
    else $error("asynchronous reset left while pin low");
  a_ram_frozen: assert property (O_RAM_IF_FREEZE |-> !O_RETAINED_RAM_EN)
    else $error("retained RAM enabled while interface frozen");
endmodule

bind wrpd_ctrl wrpd_ctrl_props u_props (
  .I_MCLK(I_MCLK), .I_SOFTWARE_RESET_INSTRUCTION(I_SOFTWARE_RESET_INSTRUCTION), .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE),
  .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST), .I_RESET_INPUT_PIN_N(I_RESET_INPUT_PIN_N),
  .I_RESET_POWERDOWN_CAP_PIN(I_RESET_POWERDOWN_CAP_PIN), .O_PINS(O_PINS),
  .O_CPU_RESET(O_CPU_RESET), .O_HOLD_CANCEL(O_HOLD_CANCEL), .O_ASYNC_RESET(O_ASYNC_RESET),
  .O_RETAINED_RAM_EN(O_RETAINED_RAM_EN), .O_RAM_IF_FREEZE(O_RAM_IF_FREEZE));

// ### bench/wrpd_board.sv
`timescale 1ns/1ps
module wrpd_board
  import wrpd_pkg::*;
(
  // Bench control
  input wire logic i_clk,
  input wire logic i_ext_low,
  input wire logic [7:0] i_rc_cycles,
  // Device side
  input wire wrpd_pins_t i_pins,
  output logic o_rst_n,
  output logic o_cap
);
  logic [7:0] cnt_q = 8'h00;
  // External pull-up; low while pressed or pulled by the device.
  assign o_rst_n = !(i_ext_low || i_pins.rst_drive_low);
  // The capacitor drains only through the weak pull-down, then recharges.
  always @(posedge i_clk) begin
    cnt_q <= i_pins.cap_pd_en ? cnt_q + 8'(cnt_q != i_rc_cycles) : 8'h00;
  end
  assign o_cap = !i_pins.cap_pd_en || (cnt_q != i_rc_cycles);
endmodule

// ### bench/wrpd_ctrl_tb.sv
`timescale 1ns/1ps
`include "wrpd_defs.svh"
module wrpd_ctrl_tb
  import wrpd_pkg::*;
;
  logic clk = 1'h0, software_reset_instruction = 1'h1, rd = 1'h0, wr = 1'h0, ext = 1'h0, nmi_n = 1'h1;
  logic rtc = 1'h0, can = 1'h0, i2c = 1'h0, seen = 1'h0;
  logic [3:0] ad = 4'h0;
  logic [31:0] wd = 32'h0, q, rdata;
  logic [7:0] fst = 8'h00, rc = 8'hC8;
  logic [12:0] cfg, latch;
  logic wq, rst_n, cap, cpu_rst, async_rst, pd;
  wrpd_pins_t pins;
  int error_cnt = 0, check_count = 0, cyc = 0;
  wrpd_ctrl #(.SEQ_CYCLES(4)) DUT (
    .I_MCLK(clk), .I_SOFTWARE_RESET_INSTRUCTION(software_reset_instruction), .I_AVS_ADDRESS(ad), .I_AVS_READ(rd), .I_AVS_WRITE(wr),
    .I_AVS_WRITEDATA(wd), .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(wq),
    .I_RESET_INPUT_PIN_N(rst_n), .I_RESET_POWERDOWN_CAP_PIN(cap), .I_NMI_N(nmi_n),
    .I_FAST_EXTERNAL_INTERRUPT_PIN(fst), .I_FAST_INT_ENABLE(8'h7F),
    .I_FAST_INT_ACTIVE_HIGH(8'hFF), .I_PORT0_CONFIG(cfg), .I_RTC_IRQ(rtc), .I_CAN_IRQ(can),
    .I_I2C_IRQ(i2c), .I_ACCESS_BUSY(1'h0), .O_PINS(pins), .O_CPU_RESET(cpu_rst),
    .O_HOLD_CANCEL(), .O_BUS_ABORT(), .O_ASYNC_RESET(async_rst), .O_POWER_DOWN(pd),
    .O_RETAINED_RAM_EN(), .O_RAM_IF_FREEZE(), .O_PORT0_LATCH(latch));
  wrpd_board u_board (.i_clk(clk), .i_ext_low(ext), .i_rc_cycles(rc), .i_pins(pins),
    .o_rst_n(rst_n), .o_cap(cap));
  initial begin
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    seen <= seen | pins.rst_drive_low;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    ad <= a;
    wd <= d;
    // Waitrequest and read data are taken as they stand at the rising edge.
    do begin
      @(posedge clk);
      n++;
    end while (wq !== 1'h0 && n < 50);
    q = rdata;
    rd <= 1'h0;
    wr <= 1'h0;
  endtask
  // Settled values are taken at the falling edge, away from the launching edge.
  task automatic wt(input bit p, input logic v);
    for (int i = 0; i < 80 && (p ? pd : cpu_rst) !== v; i++) @(negedge clk);
    chk(p ? pd : cpu_rst, v);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(26));
    cfg = 13'($urandom);
    repeat (3) @(posedge clk);
    software_reset_instruction <= 1'h0;
    bus(0, `WRPD_OFS_CTRL, 32'h0);
    chk(q, `WRPD_CTRL_RST);
    bus(0, 4'hF, 32'h0);
    chk(q, 32'h0);
    $display("test registers done");
    @(posedge clk) ext <= 1'h1;
    repeat (2) @(posedge clk);
    ext <= 1'h0;
    wt(0, 1'h1);
    chk(async_rst, 1'h0);
    chk(pins.reset_output_pin_low && pins.io_hiz, 1'h1);
    wt(0, 1'h0);
    @(posedge clk) rc <= 8'h02;
    ext <= 1'h1;
    repeat (20) @(posedge clk);
    chk(async_rst, 1'h1);
    ext <= 1'h0;
    rc <= 8'hC8;
    wt(0, 1'h0);
    $display("test hardware reset done");
    bus(1, `WRPD_OFS_CTRL, 32'h5);
    @(posedge clk) cfg <= 13'($urandom);
    seen <= 1'h0;
    bus(1, `WRPD_OFS_CMD, 32'h1);
    wt(0, 1'h0);
    chk(seen, 1'h1);
    chk(latch[12:2], {cfg[12:8], `WRPD_P0_LOWER_ONES});
    bus(0, `WRPD_OFS_CTRL, 32'h0);
    chk(q[0], 1'h0);
    $display("test software reset done");
    bus(1, `WRPD_OFS_CTRL, 32'h6);
    bus(1, `WRPD_OFS_CMD, 32'h2);
    repeat (10) @(posedge clk);
    chk(pd, 1'h0);
    nmi_n <= 1'h0;
    repeat (3) @(posedge clk);
    bus(1, `WRPD_OFS_CMD, 32'h2);
    wt(1, 1'h1);
    @(posedge clk) rtc <= 1'h1;
    nmi_n <= 1'h1;
    repeat (10) @(posedge clk);
    chk(pd, 1'h1);
    rtc <= 1'h0;
    ext <= 1'h1;
    wt(1, 1'h0);
    @(posedge clk) ext <= 1'h0;
    wt(0, 1'h0);
    $display("test protected power down done");
    @(posedge clk) fst <= 8'h81;
    bus(1, `WRPD_OFS_CTRL, 32'h26);
    bus(1, `WRPD_OFS_CMD, 32'h2);
    repeat (10) @(posedge clk);
    chk(pd, 1'h0);
    for (int s = 0; s < 5; s++) begin
      @(posedge clk) fst <= 8'h80;
      bus(1, `WRPD_OFS_CTRL, 32'h26);
      bus(1, `WRPD_OFS_CMD, 32'h2);
      wt(1, 1'h1);
      @(posedge clk) fst <= (s == 0) ? 8'h80 | (8'h01 << $urandom_range(6)) : 8'h80;
      rtc <= (s == 1);
      can <= (s == 2);
      i2c <= (s == 3);
      ext <= (s == 4);
      wt(1, 1'h0);
      @(posedge clk) {rtc, can, i2c, ext} <= 4'h0;
      wt(0, 1'h0);
    end
    $display("test interruptible power down done");
    print_verdict();
  end
endmodule
